// [prap_port.sv]
// Purpose: One channel's byte-wide reconfiguration register port
// Assumes: Host keeps one transaction outstanding and one strobe at a time
// Notes: Shared mode splits the channel from the address bits above 18
`include "prap_defines.svh"

module prap_port
    import prap_pkg::*;
#(
    parameter int CH_BITS = 2,
    parameter logic [CH_BITS-1:0] CHANNEL = '0,
    parameter bit SHARED = 1'b1,
    parameter bit HAS_STREAMER = 1'b1,
    parameter bit HAS_CAP = 1'b1,
    parameter bit HAS_CSR = 1'b1,
    parameter bit HAS_DBG = 1'b1,
    parameter logic [7:0] USER_ID = `PRAP_USER_ID_DEF // Arbitrary value
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host register port
    input wire logic write,
    input wire logic read,
    input wire logic [`PRAP_ADDR_W+CH_BITS-1:0] address,
    input wire logic [7:0] writedata,
    output prap_byte_t readdata,
    output logic waitrequest,
    // Debug master endpoint access
    input wire logic dbg_write,
    input wire logic dbg_read,
    input wire logic [`PRAP_ADDR_W-1:0] dbg_address,
    input wire logic [7:0] dbg_writedata,
    output prap_byte_t dbg_readdata,
    output logic dbg_waitrequest,
    // Channel control and status
    input wire logic [7:0] chan_status,
    output logic [7:0] chan_control,
    // Front-end state
    output prap_byte_t fe_setting,
    output logic [15:0] fe_attr_code,
    output logic [15:0] fe_attr_value,
    output logic fe_attr_strobe
);
    prap_acc_e state;
    prap_acc_e next_state;
    logic [1:0] wait_cnt;
    logic host_sel;
    logic dbg_sel;
    logic [7:0] chan_status_m;
    logic [7:0] chan_status_s;
    logic chg_flag;
    logic reload_busy;
    logic [2:0] load_sel;
    logic load_done;
    logic [7:0] init_setting;
    prap_byte_t attr_lo;
    prap_byte_t attr_hi;
    prap_byte_t code_lo;
    logic rel_done;
    logic str_busy;
    logic str_done;
    logic [2:0] str_last;
    prap_byte_t str_setting;
    prap_byte_t rd_mux;
    logic own_dbg;

    // ==========================================================
    // Access decode
    // Host owns the port when it strobes; debug master only when host is idle
    wire host_req = write || read;
    wire [CH_BITS-1:0] ch_field = address[`PRAP_ADDR_W+CH_BITS-1:`PRAP_ADDR_W];
    wire ch_match = !SHARED || (ch_field == CHANNEL);
    wire dbg_req = HAS_DBG && (dbg_write || dbg_read) && !host_req;
    wire take = (state == PRAP_IDLE) && ((host_req && ch_match) || dbg_req);
    wire take_dbg = (state == PRAP_IDLE) && !host_req && dbg_req;
    // Owner is held through the busy phase; host lines may move under a debug access
    wire use_dbg = (state == PRAP_IDLE) ? take_dbg : own_dbg;
    wire [`PRAP_ADDR_W-1:0] reg_addr = use_dbg ? dbg_address
                                               : address[`PRAP_ADDR_W-1:0];
    wire do_wr = take && (take_dbg ? dbg_write : write);
    wire [7:0] wr_data = take_dbg ? dbg_writedata : writedata;
    wire hit_chg = (reg_addr == `PRAP_OFS_CHG_STAT);
    wire hit_rel = (reg_addr == `PRAP_OFS_RELOAD);
    wire hit_ctrl = (reg_addr == `PRAP_OFS_CTRL);
    wire wr_reload = do_wr && hit_rel && (wr_data == `PRAP_RELOAD_CMD);
    wire wr_chg_clr = do_wr && hit_chg && wr_data[`PRAP_BIT_CHG];
    wire wr_load = HAS_CSR && do_wr && hit_ctrl && wr_data[`PRAP_BIT_LOAD_GO];
    wire str_go = HAS_STREAMER && wr_load;
    wire wr_attr_hi = do_wr && (reg_addr == `PRAP_OFS_ATTR_CODE_HI);

    // ==========================================================
    // Access state machine: waitrequest high while a command is in work
    always_comb begin
        next_state = state;
        unique case (state)
            PRAP_IDLE: begin
                if (take) begin
                    next_state = PRAP_BUSY;
                end
            end
            PRAP_BUSY: begin
                if (wait_cnt == 2'h0) begin
                    next_state = PRAP_DONE;
                end
            end
            PRAP_DONE: begin
                next_state = PRAP_IDLE;
            end
        endcase
    end

    // Reset is synchronous, so its release is clock-aligned by construction
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= PRAP_IDLE;
            wait_cnt <= 2'h0;
            own_dbg <= 1'b0;
        end else begin
            state <= next_state;
            own_dbg <= take ? take_dbg : own_dbg;
            wait_cnt <= take ? `PRAP_READ_WAIT : wait_cnt - 2'(wait_cnt != 2'h0);
        end
    end

    // Busy from the first strobe cycle so the host holds its command
    assign host_sel = host_req && ch_match && !take_dbg;
    assign dbg_sel = dbg_req;
    assign waitrequest = host_sel && (state != PRAP_DONE);
    assign dbg_waitrequest = dbg_sel && (state != PRAP_DONE);

    // ==========================================================
    // Status input synchroniser: channel status comes from another domain
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_status_m <= 8'h00;
            chan_status_s <= 8'h00;
        end else begin
            chan_status_m <= chan_status;
            chan_status_s <= chan_status_m;
        end
    end

    // ==========================================================
    // Reload and profile-change flag
    // A completion in the same cycle as the host clear keeps the flag set
    always_ff @(posedge clk) begin
        if (rst) begin
            chg_flag <= 1'b0;
            reload_busy <= 1'b0;
        end else begin
            if (rel_done || str_done) begin
                chg_flag <= 1'b1;
            end else if (wr_chg_clr) begin
                chg_flag <= 1'b0;
            end
            if (wr_reload) begin
                reload_busy <= 1'b1;
            end else if (rel_done) begin
                reload_busy <= 1'b0;
            end
        end
    end

    prap_apply_timer u_reload_tmr (
        .clk(clk),
        .rst(rst),
        .start(wr_reload),
        .busy(),
        .done(rel_done)
    );

    // ==========================================================
    // Soft control registers and attribute staging
    always_ff @(posedge clk) begin
        if (rst) begin
            chan_control <= `PRAP_RST_BYTE;
            load_sel <= 3'h0;
            load_done <= 1'b0;
            attr_lo <= `PRAP_RST_BYTE;
            attr_hi <= `PRAP_RST_BYTE;
            code_lo <= `PRAP_RST_BYTE;
            fe_attr_code <= 16'h0000;
            fe_attr_value <= 16'h0000;
            fe_attr_strobe <= 1'b0;
        end else begin
            fe_attr_strobe <= wr_attr_hi;
            if (wr_load) begin
                load_sel <= wr_data[2:0];
                load_done <= 1'b0;
            end else if (str_done) begin
                load_done <= 1'b1;
            end
            if (HAS_CSR && do_wr && (reg_addr == `PRAP_OFS_STAT)) begin
                chan_control <= wr_data;
            end
            if (do_wr && (reg_addr == `PRAP_OFS_ATTR_LO)) begin
                attr_lo <= wr_data;
            end
            if (do_wr && (reg_addr == `PRAP_OFS_ATTR_HI)) begin
                attr_hi <= wr_data;
            end
            if (do_wr && (reg_addr == `PRAP_OFS_ATTR_CODE_LO)) begin
                code_lo <= wr_data;
            end
            // Order of codes is the host's duty; the port just forwards them
            if (wr_attr_hi) begin
                fe_attr_code <= {wr_data, code_lo};
                fe_attr_value <= {attr_hi, attr_lo};
            end
        end
    end

    // ==========================================================
    // Embedded streamer
    prap_streamer u_str (
        .clk(clk),
        .rst(rst),
        .go(str_go),
        .prof_sel(wr_data[2:0]),
        .last_prof(str_last),
        .setting(str_setting),
        .busy(str_busy),
        .done(str_done)
    );

    // Initial setting used when no streamer is built in
    assign init_setting = 8'h10;

    // Reload restores the initial set, or the last streamed profile
    always_ff @(posedge clk) begin
        if (rst) begin
            fe_setting <= `PRAP_RST_BYTE;
        end else if (rel_done) begin
            fe_setting <= HAS_STREAMER ? str_setting : init_setting;
        end else if (str_done) begin
            fe_setting <= str_setting;
        end
    end

    // ==========================================================
    // Read path: data captured as the busy phase ends
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr == `PRAP_OFS_CHG_STAT) begin
            rd_mux = {chg_flag, 7'h00};
        end else if (reg_addr == `PRAP_OFS_RELOAD) begin
            rd_mux = {7'h00, reload_busy};
        end else if (HAS_CAP && reg_addr == `PRAP_OFS_USER_ID) begin
            rd_mux = USER_ID;
        end else if (HAS_CSR && reg_addr == `PRAP_OFS_CTRL) begin
            rd_mux = {str_busy, 4'h0, HAS_STREAMER ? str_last : load_sel};
        end else if (HAS_CSR && reg_addr == `PRAP_OFS_STAT) begin
            rd_mux = {chan_status_s[7:1], load_done};
        end
    end

    // Host data changes only at the end of a host read, debug data at the end of any debug access; both are stable after waitrequest falls
    always_ff @(posedge clk) begin
        if (rst) begin
            readdata <= `PRAP_RST_BYTE;
            dbg_readdata <= `PRAP_RST_BYTE;
        end else if (state == PRAP_BUSY && wait_cnt == 2'h0) begin
            if (own_dbg) begin
                dbg_readdata <= rd_mux;
            end else if (read) begin
                readdata <= rd_mux;
            end
        end
    end
endmodule

// [prap_defines.svh]
// Purpose: Constants of the front-end reconfiguration access port
// Assumes: Included by every design file of the port
// Notes: Offsets are register addresses in the low 19 address bits
// Contract
// - Write 0x01 to settings_reload_request reloads; bit self-clears
// - Reload restores initial or last profile
// - Device sets profile_change_status bit 7 after change
// - Writing one to profile_change_status bit 7 clears it
// - Shared port: bits above 18 select channel
// - Port reset releases synchronously to clock
// - Read and write strobes active high
// - Separate eight-bit write and read buses
// - Read data valid after waitrequest falls
// - Waitrequest high while busy; host holds command
// - Unshared mode gives each channel own port
// - Capability location returns build-time user identifier
// - Soft control and status registers reachable
// - One to eight profiles, indexed 0 to 7
// - Streamer writes profile registers without host
// - Debug master endpoint can access port
`ifndef PRAP_DEFINES_SVH
`define PRAP_DEFINES_SVH

// ==========================================================
// Address map
`define PRAP_ADDR_W 19
`define PRAP_OFS_CHG_STAT 19'h0008A
`define PRAP_OFS_RELOAD 19'h00091
`define PRAP_OFS_USER_ID 19'h40000
`define PRAP_OFS_CTRL 19'h40143
`define PRAP_OFS_STAT 19'h40144
`define PRAP_OFS_ATTR_LO 19'h00084
`define PRAP_OFS_ATTR_HI 19'h00085
`define PRAP_OFS_ATTR_CODE_LO 19'h00086
`define PRAP_OFS_ATTR_CODE_HI 19'h00087

// ==========================================================
// Fields and values
`define PRAP_BIT_CHG 7
`define PRAP_BIT_RELOAD 0
`define PRAP_BIT_LOAD_GO 7
`define PRAP_RELOAD_CMD 8'h01
`define PRAP_RST_BYTE 8'h00
`define PRAP_USER_ID_DEF 8'h5A
`define PRAP_NUM_PROF 8

// ==========================================================
// Timing
`define PRAP_READ_WAIT 2'h2
`define PRAP_APPLY_CYC 4'h8

`endif

// [prap_pkg.sv]
// Purpose: Types of the front-end reconfiguration access port
// Assumes: Nothing beyond the defines header
// Notes: Holds the access state machine type
package prap_pkg;
    typedef enum logic [1:0] {
        PRAP_IDLE,
        PRAP_BUSY,
        PRAP_DONE
    } prap_acc_e;
    typedef logic [7:0] prap_byte_t;
endpackage

// [prap_apply_timer.sv]
// Purpose: Counts the time the front end needs to apply a setting set
// Assumes: start is a one-cycle pulse
// Notes: A restart while busy restarts the count
`include "prap_defines.svh"

module prap_apply_timer
    import prap_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic start,
    output logic busy,
    output logic done
);
    logic [3:0] count;

    // ==========================================================
    // Countdown
    // Done is a pulse so the owner can raise a sticky flag once
    always_ff @(posedge clk) begin
        if (rst) begin
            count <= 4'h0;
            done <= 1'b0;
        end else begin
            done <= (count == 4'h1);
            if (start) begin
                count <= `PRAP_APPLY_CYC;
            end else if (count != 4'h0) begin
                count <= count - 4'h1;
            end
        end
    end

    assign busy = (count != 4'h0);
endmodule

// [prap_streamer.sv]
// Purpose: Embedded streamer that switches to a stored profile on its own
// Assumes: go is a one-cycle pulse; profile index below the profile count
// Notes: Each profile is reduced here to one stored setting byte
`include "prap_defines.svh"

module prap_streamer
    import prap_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Command
    input wire logic go,
    input wire logic [2:0] prof_sel,
    // Result
    output logic [2:0] last_prof,
    output prap_byte_t setting,
    output logic busy,
    output logic done
);
    prap_byte_t prof_mem [`PRAP_NUM_PROF];
    logic run;
    logic [2:0] pend;
    logic tmr_done;

    // Stored profiles are build-time constants
    genvar g;
    generate
        for (g = 0; g < `PRAP_NUM_PROF; g++) begin : g_prof
            assign prof_mem[g] = 8'h10 + 8'(g);
        end
    endgenerate

    // ==========================================================
    // Profile switch without the host
    always_ff @(posedge clk) begin
        if (rst) begin
            run <= 1'b0;
            pend <= 3'h0;
            last_prof <= 3'h0;
            setting <= prof_mem[3'h0]; // Profile 0 counts as selected until a load
        end else if (go && !run) begin
            run <= 1'b1;
            pend <= prof_sel;
        end else if (run && tmr_done) begin
            run <= 1'b0;
            last_prof <= pend;
            setting <= prof_mem[pend];
        end
    end

    prap_apply_timer u_tmr (
        .clk(clk),
        .rst(rst),
        .start(go && !run),
        .busy(),
        .done(tmr_done)
    );

    assign busy = run;

    // Done rises on the same edge as the setting update so the owner captures the new byte
    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= run && tmr_done;
        end
    end
endmodule

// [prap_host_model.sv]
// Purpose: Host side of the byte-wide register port, issuing one access at a time
// Assumes: Requests change at the falling clock edge
// Notes: Released address and data lines show the inverse of the last value
`include "prap_defines.svh"

module prap_host_model #(
    parameter int AW = 21
)
(
    // Clock
    input wire logic clk,
    // Request
    output logic write,
    output logic read,
    output logic [AW-1:0] address,
    output logic [7:0] writedata,
    // Answer
    input wire logic [7:0] readdata,
    input wire logic waitrequest
);
    int timeouts = 0;

    // ==========================================================
    // Idle levels
    initial begin
        write = 1'b0;
        read = 1'b0;
        address = '0;
        writedata = 8'h00;
    end

    // One access; the command is held until the port stops waiting
    task automatic acc(input logic we, input logic [AW-1:0] a, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        @(negedge clk);
        write = we;
        read = !we;
        address = a;
        writedata = wd;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 30);
        if (waitrequest !== 1'b0) begin
            timeouts++;
        end
        rd = readdata;
        write = 1'b0;
        read = 1'b0;
        address = ~a;
        writedata = ~wd;
    endtask

    // Read strobe aimed at an address that the port must ignore
    task automatic stray(input logic [AW-1:0] a, output logic seen);
        seen = 1'b0;
        @(negedge clk);
        read = 1'b1;
        address = a;
        repeat (4) begin
            @(negedge clk);
            seen |= waitrequest;
        end
        read = 1'b0;
        address = ~a;
    endtask
endmodule

// [prap_checker.sv]
// Purpose: Port timing and side-effect checks of the register port
// Assumes: Host never overlaps its own port with the debug port
// Notes: Bound onto every port instance
`include "prap_defines.svh"

module prap_checker
    import prap_pkg::*;
#(
    parameter int CH_BITS = 2,
    parameter logic [CH_BITS-1:0] CHANNEL = '0,
    parameter bit SHARED = 1'b1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host port
    input wire logic write,
    input wire logic read,
    input wire logic [`PRAP_ADDR_W+CH_BITS-1:0] address,
    input wire logic [7:0] writedata,
    input wire prap_byte_t readdata,
    input wire logic waitrequest,
    // Debug port and outputs
    input wire logic dbg_write,
    input wire logic dbg_read,
    input wire logic dbg_waitrequest,
    input wire logic [7:0] chan_control,
    input wire logic [15:0] fe_attr_code,
    input wire logic fe_attr_strobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Channel match and transfer steps
    wire logic sel = !SHARED || address[`PRAP_ADDR_W+CH_BITS-1:`PRAP_ADDR_W] == CHANNEL;
    wire logic [18:0] reg_ofs = address[18:0];
    sequence host_take;
        $rose(read || write) && sel && !(dbg_read || dbg_write);
    endsequence
    sequence busy_then_done;
        waitrequest[*4] ##1 !waitrequest;
    endsequence

    wait_len_a: assert property (host_take |-> busy_then_done)
        else $error("waitrequest length wrong");
    idle_quiet_a: assert property (!read && !write |-> !waitrequest)
        else $error("waitrequest without command");
    foreign_ch_a: assert property ((read || write) && !sel |-> !waitrequest)
        else $error("foreign channel answered");
    rdata_update_a: assert property ($changed(readdata) |-> !waitrequest && $past(waitrequest))
        else $error("readdata moved outside read end");
    rdata_keep_a: assert property ($rose(write) && sel |-> ##1 $stable(readdata)[*4])
        else $error("write disturbed readdata");
    attr_fire_a: assert property ($rose(write) && sel && reg_ofs == `PRAP_OFS_ATTR_CODE_HI
        |=> fe_attr_strobe && fe_attr_code[15:8] == $past(writedata) ##1 !fe_attr_strobe)
        else $error("attribute strobe wrong");
    ctrl_store_a: assert property ($rose(write) && sel && reg_ofs == `PRAP_OFS_STAT
        |=> chan_control == $past(writedata))
        else $error("control write not stored");
    dbg_busy_a: assert property ($rose(dbg_read) && !(read || write)
        |-> dbg_waitrequest[*4] ##1 !dbg_waitrequest)
        else $error("debug waitrequest wrong");
endmodule

bind prap_port prap_checker #(.CH_BITS(CH_BITS), .CHANNEL(CHANNEL), .SHARED(SHARED)) i_chk (
    .clk(clk), .rst(rst), .write(write), .read(read), .address(address),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .dbg_write(dbg_write), .dbg_read(dbg_read), .dbg_waitrequest(dbg_waitrequest),
    .chan_control(chan_control), .fe_attr_code(fe_attr_code),
    .fe_attr_strobe(fe_attr_strobe));

// [tb_pma_reconfig_access_port.sv]
// Purpose: Self-checking bench of the register port
// Assumes: Port built shared, for channel 1, with all options present
// Notes: Waits after reload and profile loads are generous fixed spans
`include "prap_defines.svh"

module tb_pma_reconfig_access_port;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [1:0] CH = 2'h1;
    localparam logic [7:0] UID = 8'hA5; // Arbitrary identifier
    localparam logic [15:0] CODES [6] = '{16'h0005, 16'h0006, 16'h0014,
                                          16'h0015, 16'h0011, 16'h0001};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic write, read, dbg_write, dbg_read, waitrequest, dbg_waitrequest, fe_attr_strobe, seen;
    logic [20:0] address;
    logic [18:0] dbg_address;
    logic [7:0] writedata, readdata, dbg_writedata, dbg_readdata, chan_control, fe_setting, rd;
    logic [7:0] chan_status = 8'h55;
    logic [15:0] fe_attr_code, fe_attr_value;
    int n_fail = 0;
    int tests_run = 0;

    always #10 clk = ~clk; // house clock; the port logic has no rate limit

    // ==========================================================
    // Design and the two requesters
    prap_port #(.CH_BITS(2), .CHANNEL(CH), .USER_ID(UID)) i_dut (
        .clk(clk), .rst(rst), .write(write), .read(read), .address(address),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .dbg_write(dbg_write), .dbg_read(dbg_read), .dbg_address(dbg_address),
        .dbg_writedata(dbg_writedata), .dbg_readdata(dbg_readdata),
        .dbg_waitrequest(dbg_waitrequest), .chan_status(chan_status),
        .chan_control(chan_control), .fe_setting(fe_setting), .fe_attr_code(fe_attr_code),
        .fe_attr_value(fe_attr_value), .fe_attr_strobe(fe_attr_strobe));
    prap_host_model #(.AW(21)) i_host (.clk(clk), .write(write), .read(read),
        .address(address), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest));
    prap_host_model #(.AW(19)) i_dbg (.clk(clk), .write(dbg_write), .read(dbg_read),
        .address(dbg_address), .writedata(dbg_writedata), .readdata(dbg_readdata),
        .waitrequest(dbg_waitrequest));

    // ==========================================================
    // Access and comparison helpers
    task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
        tests_run++;
        if (seen_v !== exp_v) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        i_host.acc(1'b1, {CH, a}, d, rd);
    endtask
    task automatic rdc(input logic [18:0] a, input logic [7:0] e);
        i_host.acc(1'b0, {CH, a}, 8'h00, rd);
        chk(rd, e);
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        stop_test();
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        rdc(`PRAP_OFS_CHG_STAT, 8'h00);
        rdc(`PRAP_OFS_RELOAD, 8'h00);
        $display("Test reset values done");
        wr(`PRAP_OFS_RELOAD, `PRAP_RELOAD_CMD);
        rdc(`PRAP_OFS_RELOAD, 8'h01);
        repeat (20) @(negedge clk);
        rdc(`PRAP_OFS_RELOAD, 8'h00);
        rdc(`PRAP_OFS_CHG_STAT, 8'h80);
        chk(fe_setting, 8'h10);
        wr(`PRAP_OFS_CHG_STAT, 8'h80);
        rdc(`PRAP_OFS_CHG_STAT, 8'h00);
        $display("Test initial reload done");
        for (int p = 0; p < 8; p++) begin
            wr(`PRAP_OFS_CTRL, 8'h80 | 8'(p));
            repeat (24) @(negedge clk);
            chk(fe_setting, 8'h10 + 8'(p));
            rdc(`PRAP_OFS_STAT, {chan_status[7:1], 1'b1});
        end
        rdc(`PRAP_OFS_CHG_STAT, 8'h80);
        wr(`PRAP_OFS_CHG_STAT, 8'h80);
        wr(`PRAP_OFS_RELOAD, `PRAP_RELOAD_CMD);
        repeat (20) @(negedge clk);
        chk(fe_setting, 8'h17);
        rdc(`PRAP_OFS_RELOAD, 8'h00);
        rdc(`PRAP_OFS_CHG_STAT, 8'h80);
        wr(`PRAP_OFS_CHG_STAT, 8'h80);
        $display("Test profiles done");
        foreach (CODES[i]) begin
            wr(`PRAP_OFS_ATTR_LO, ~CODES[i][7:0]);
            wr(`PRAP_OFS_ATTR_HI, ~CODES[i][15:8]);
            wr(`PRAP_OFS_ATTR_CODE_LO, CODES[i][7:0]);
            wr(`PRAP_OFS_ATTR_CODE_HI, CODES[i][15:8]);
            chk(fe_attr_code, CODES[i]);
            chk(fe_attr_value, ~CODES[i]);
        end
        chk(fe_attr_code, 16'h0001);
        $display("Test attributes done");
        i_host.stray({2'h0, `PRAP_OFS_USER_ID}, seen);
        chk({15'h0000, seen}, 16'h0000);
        i_host.stray({2'h2, `PRAP_OFS_USER_ID}, seen);
        chk({15'h0000, seen}, 16'h0000);
        rdc(`PRAP_OFS_USER_ID, UID);
        rdc(19'h00123, 8'h00);
        wr(`PRAP_OFS_STAT, 8'h3C);
        chk(chan_control, 8'h3C);
        i_dbg.acc(1'b0, `PRAP_OFS_USER_ID, 8'h00, rd);
        chk(rd, UID);
        i_dbg.acc(1'b1, `PRAP_OFS_STAT, 8'hC3, rd);
        chk(chan_control, 8'hC3);
        $display("Test channel, capability and debug done");
        wr(`PRAP_OFS_RELOAD, `PRAP_RELOAD_CMD);
        repeat (20) @(negedge clk);
        rst = 1'b1;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        rdc(`PRAP_OFS_CHG_STAT, 8'h00);
        chk(chan_control, 8'h00);
        chk(16'(i_host.timeouts), 16'h0000);
        chk(16'(i_dbg.timeouts), 16'h0000);
        $display("Test second reset done");
        stop_test();
    end
endmodule
